/* File: design/mio_pin_map.vh */
`ifndef MIO_PIN_MAP_VH
`define MIO_PIN_MAP_VH

// Command bus width codes
`define WIDTH_SINGLE      2'h0
`define WIDTH_DUAL        2'h1
`define WIDTH_QUAD        2'h2

// Reset pulse least time in ns, and the clock period in ns
`define RESET_PULSE_NS    200
`define CLOCK_PERIOD_NS   50
`define RESET_PULSE_CYC   ((`RESET_PULSE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// Width of the reset pulse counter
`define RESET_CNT_W       8

`endif

/* File: design/pin_sync.v */
`timescale 1ns/100ps
// Two-flop synchroniser for a bank of pin levels
module pin_sync #(
    parameter             WIDTH     = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
    input  wire             clock_in,
    input  wire             rst_in,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    stage1_q[i] <= RESET_VAL[i];
                    stage2_q[i] <= RESET_VAL[i];
                end else begin
                    stage1_q[i] <= async_in[i];
                    stage2_q[i] <= stage1_q[i];
                end
            end
        end
    endgenerate
    assign sync_out = stage2_q;
endmodule

/* File: design/spi_mio_pin_role_select.v */
`timescale 1ns/100ps
`include "mio_pin_map.vh"
module spi_mio_pin_role_select #(
    parameter RESET_PULSE_CYCLES = `RESET_PULSE_CYC
) (
    input  wire       clock_in,
    input  wire       rst_in,
    input  wire       serial_clock_in,
    input  wire       chip_select_n_in,
    input  wire [3:0] data_pin_in,
    input  wire       quad_enable_bit_in,
    input  wire       protect_lock_bit_in,
    input  wire       pin_reset_enable_bit_in,
    input  wire [1:0] cmd_width_in,
    input  wire       out_phase_in,
    input  wire [3:0] out_data_in,
    input  wire       reg_write_req_in,
    input  wire       reg_write_protected_in,
    output reg  [3:0] data_pin_out,
    output reg  [3:0] data_pin_oe_out,
    output reg  [3:0] rx_data_out,
    output reg        serial_clock_out,
    output reg        write_protect_active_out,
    output reg        reg_write_ok_out,
    output reg        reg_write_dropped_out,
    output reg        pin_reset_out
);
    localparam       SYNC_W          = 6;
    localparam [3:0] SINGLE_OUT_PINS = 4'h2;

    wire [SYNC_W-1:0] pin_sync_w;
    wire              cs_n_s;
    wire              sck_s;
    wire [3:0]        pin_s;

    // Serial clock idles low; select and pins idle high as if pulled up
    pin_sync #(
        .WIDTH     (SYNC_W),
        .RESET_VAL (6'h1f)
    ) u_sync (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .async_in ({serial_clock_in, chip_select_n_in, data_pin_in}),
        .sync_out (pin_sync_w)
    );

    assign sck_s  = pin_sync_w[5];
    assign cs_n_s = pin_sync_w[4];
    assign pin_s  = pin_sync_w[3:0];

    // True for single-bit command width
    function is_single;
        input [1:0] width;
        begin
            is_single = (width == `WIDTH_SINGLE);
        end
    endfunction

    // True for quad command width
    function is_quad;
        input [1:0] width;
        begin
            is_quad = (width == `WIDTH_QUAD);
        end
    endfunction

    // Role of each pin as a data line
    function [3:0] data_roles;
        input [1:0] width;
        input       quad_en;
        input       cs_n;
        begin
            data_roles[0] = !is_single(width);
            data_roles[1] = !is_single(width);
            data_roles[2] = quad_en && is_quad(width);
            data_roles[3] = quad_en && !cs_n && is_quad(width);
        end
    endfunction

    // Pin two carries write protect
    function protect_role;
        input quad_en;
        input lock;
        begin
            protect_role = !quad_en && lock;
        end
    endfunction

    // Pin three carries the reset input
    function reset_role;
        input rst_en;
        input quad_en;
        input cs_n;
        begin
            reset_role = rst_en && (!quad_en || cs_n);
        end
    endfunction

    reg [3:0] role_w;
    reg       protect_role_w;
    reg       reset_role_w;
    reg       reset_low_w;
    reg       wp_low_w;
    reg       drop_w;

    always @* begin
        role_w = data_roles(cmd_width_in, quad_enable_bit_in, cs_n_s);
        protect_role_w = protect_role(quad_enable_bit_in,
                                      protect_lock_bit_in);
        reset_role_w = reset_role(pin_reset_enable_bit_in,
                                  quad_enable_bit_in, cs_n_s);
        reset_low_w = reset_role_w && cs_n_s && !pin_s[3];
        // relies on host driving a firm level here
        wp_low_w = protect_role_w && !pin_s[2];
        drop_w = wp_low_w && reg_write_protected_in;
    end

    wire [3:0] single_out_w;
    wire [3:0] single_rx_w;
    wire [3:0] pin_out_d;
    wire [3:0] pin_rx_d;
    wire [3:0] pin_oe_d;

    // Single width sends on pin one and receives on pin zero only
    assign single_out_w = {2'h0, out_data_in[0], 1'b0};
    assign single_rx_w  = {3'h0, pin_s[0]};

    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_pin
            assign pin_oe_d[p] = out_phase_in && !cs_n_s &&
                                 (is_single(cmd_width_in) ?
                                  SINGLE_OUT_PINS[p] : role_w[p]);
            assign pin_out_d[p] = is_single(cmd_width_in) ?
                                  single_out_w[p] :
                                  (out_data_in[p] && role_w[p]);
            assign pin_rx_d[p] = is_single(cmd_width_in) ?
                                 single_rx_w[p] :
                                 (pin_s[p] && role_w[p]);
        end
    endgenerate

    reg [`RESET_CNT_W-1:0] rst_cnt_q;
    reg [`RESET_CNT_W-1:0] rst_cnt_d;
    reg                    pulse_done_w;

    always @* begin
        rst_cnt_d = {`RESET_CNT_W{1'b0}};
        if (reset_low_w) begin
            if (rst_cnt_q < RESET_PULSE_CYCLES[`RESET_CNT_W-1:0])
                rst_cnt_d = rst_cnt_q + 1'b1;
            else
                rst_cnt_d = rst_cnt_q;
        end
        pulse_done_w = reset_low_w &&
            (rst_cnt_d >= RESET_PULSE_CYCLES[`RESET_CNT_W-1:0]);
    end

    // Pin drive and receive registers
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            data_pin_out    <= 4'h0;
            data_pin_oe_out <= 4'h0;
            rx_data_out     <= 4'h0;
        end else begin
            data_pin_out    <= pin_out_d;
            data_pin_oe_out <= pin_oe_d;
            rx_data_out     <= pin_rx_d;
        end
    end

    // Serial clock copy, already two flops deep
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in)
            serial_clock_out <= 1'b0;
        else
            serial_clock_out <= sck_s;
    end

    // Protect status and register write verdicts
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            write_protect_active_out <= 1'b0;
            reg_write_ok_out         <= 1'b0;
            reg_write_dropped_out    <= 1'b0;
        end else begin
            write_protect_active_out <= wp_low_w;
            reg_write_ok_out      <= reg_write_req_in && !drop_w;
            reg_write_dropped_out <= reg_write_req_in && drop_w;
        end
    end

    // Reset recognition; a short glitch restarts the count
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rst_cnt_q     <= {`RESET_CNT_W{1'b0}};
            pin_reset_out <= 1'b0;
        end else begin
            rst_cnt_q     <= rst_cnt_d;
            pin_reset_out <= pulse_done_w;
        end
    end
endmodule

/* File: tb/spi_mio_pin_role_select_asserts.sv */
`timescale 1ns/100ps
module spi_mio_pin_role_select_asserts (
    input wire       clock_in, rst_in, chip_select_n_in, out_phase_in,
    input wire       quad_enable_bit_in, protect_lock_bit_in,
    input wire       pin_reset_enable_bit_in, reg_write_req_in,
    input wire       reg_write_protected_in, write_protect_active_out,
    input wire       reg_write_ok_out, reg_write_dropped_out, pin_reset_out,
    input wire [1:0] cmd_width_in,
    input wire [3:0] data_pin_in, data_pin_oe_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // Four cycles cover two sync flops plus the output register
    wire act = !chip_select_n_in && out_phase_in;
    wire wp_low = !quad_enable_bit_in && protect_lock_bit_in && !data_pin_in[2];
    property p_idle; chip_select_n_in[*4] |=> data_pin_oe_out == 4'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("oe while idle");
    property p_single; (act && cmd_width_in == 2'h0)[*4]
        |=> data_pin_oe_out == 4'h2; endproperty
    a_single: assert property (p_single) else $error("single oe");
    property p_quad; (act && quad_enable_bit_in && cmd_width_in == 2'h2)[*4]
        |=> data_pin_oe_out == 4'hf; endproperty
    a_quad: assert property (p_quad) else $error("quad oe");
    property p_wp; wp_low[*4] |=> write_protect_active_out; endproperty
    a_wp: assert property (p_wp) else $error("protect missing");
    property p_nowp; quad_enable_bit_in[*4] |=> !write_protect_active_out;
    endproperty
    a_nowp: assert property (p_nowp) else $error("protect in quad");
    property p_drop; wp_low[*4] ##0 (reg_write_req_in && reg_write_protected_in)
        |=> reg_write_dropped_out && !reg_write_ok_out; endproperty
    a_drop: assert property (p_drop) else $error("write not dropped");
    property p_rst; (pin_reset_enable_bit_in && chip_select_n_in
        && !data_pin_in[3])[*8] |=> pin_reset_out; endproperty
    a_rst: assert property (p_rst) else $error("reset missed");
    property p_rq; (quad_enable_bit_in && !chip_select_n_in)[*5]
        |=> !pin_reset_out; endproperty
    a_rq: assert property (p_rq) else $error("reset in quad");
endmodule
bind spi_mio_pin_role_select spi_mio_pin_role_select_asserts chk_inst (.*);

/* File: tb/spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic       frame,
    input  wire logic       hoe,
    input  wire logic [3:0] hval,
    input  wire logic [3:0] data_pin_out,
    input  wire logic [3:0] data_pin_oe_out,
    output logic            serial_clock_in,
    output wire logic       chip_select_n_in,
    output wire logic [3:0] data_pin_in
);
    wire [3:0] host_lvl = hoe ? hval : {2'h3, ~hval[1:0]};
    initial serial_clock_in = 1'b0;
    // Clock stands low between frames
    always #200 serial_clock_in = frame & ~serial_clock_in;
    assign chip_select_n_in = ~frame;
    assign data_pin_in = (data_pin_oe_out & data_pin_out)
        | (~data_pin_oe_out & host_lvl);
endmodule

/* File: tb/spi_mio_pin_role_select_bench.sv */
`timescale 1ns/100ps
module spi_mio_pin_role_select_bench;
    logic       clock_in = 0, rst_in = 1, frame = 0, hoe = 1;
    logic       quad_enable_bit_in = 0, protect_lock_bit_in = 0;
    logic       pin_reset_enable_bit_in = 0, out_phase_in = 0;
    logic       reg_write_req_in = 0, reg_write_protected_in = 0;
    logic [1:0] cmd_width_in = 0;
    logic [3:0] hval = 4'hf, out_data_in = 4'h0;
    wire        serial_clock_in, chip_select_n_in, serial_clock_out;
    wire        write_protect_active_out, reg_write_ok_out;
    wire        reg_write_dropped_out, pin_reset_out;
    wire  [3:0] data_pin_in, data_pin_out, data_pin_oe_out, rx_data_out;
    int         miscompares = 0, checked = 0;
    spi_mio_pin_role_select #(.RESET_PULSE_CYCLES(2))
        spi_mio_pin_role_select_inst (.*);
    spi_host_model spi_host_model_inst (.*);
    always #25 clock_in = ~clock_in;
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic t_roles;
        frame = 1; quad_enable_bit_in = 1; out_phase_in = 1; out_data_in = 4'hb;
        wait_n(5); chk(data_pin_oe_out, 4'h2);
        chk(data_pin_out, 4'h2);
        chk(rx_data_out, 4'h1);
        @(posedge serial_clock_in); wait_n(4);
        chk({3'h0, serial_clock_out}, 4'h1);
        cmd_width_in = 1; wait_n(5); chk(data_pin_oe_out, 4'h3);
        cmd_width_in = 2; wait_n(5); chk(data_pin_in, 4'hb);
        out_phase_in = 0; hval = 4'h5; wait_n(5); chk(rx_data_out, 4'h5);
        frame = 0; out_phase_in = 1; wait_n(5); chk(data_pin_oe_out, 4'h0);
        wait_n(6); chk({3'h0, serial_clock_out}, 4'h0);
        out_phase_in = 0;
    endtask
    task automatic t_protect;
        quad_enable_bit_in = 0; protect_lock_bit_in = 1; hval = 4'hb;
        wait_n(5); chk({3'h0, write_protect_active_out}, 4'h1);
        reg_write_protected_in = 1; reg_write_req_in = 1; wait_n(1);
        reg_write_req_in = 0;
        chk({2'h0, reg_write_ok_out, reg_write_dropped_out}, 4'h1);
        hval = 4'hf; wait_n(5); reg_write_req_in = 1; wait_n(1);
        reg_write_req_in = 0;
        chk({2'h0, reg_write_ok_out, reg_write_dropped_out}, 4'h2);
        quad_enable_bit_in = 1; hval = 4'hb;
        wait_n(5); chk({3'h0, write_protect_active_out}, 4'h0);
    endtask
    task automatic t_reset;
        quad_enable_bit_in = 0; pin_reset_enable_bit_in = 1; hval = 4'h7;
        wait_n(8); chk({3'h0, pin_reset_out}, 4'h1);
        quad_enable_bit_in = 1; frame = 1;
        wait_n(5); chk({3'h0, pin_reset_out}, 4'h0);
    endtask
    task automatic summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        wait_n(3); rst_in = 0; wait_n(3);
        t_roles; t_protect; t_reset; summarize;
    end
    // Whole run needs about 4 us
    initial begin
        #100000; miscompares++; summarize;
    end
endmodule
